/* mms_consts.svh */
// mms_consts.svh: offsets, field positions, reset values and vectors of the mode/map block.
// assumes it is included by bare name from the package and the design modules.
`ifndef MMS_CONSTS_SVH
`define MMS_CONSTS_SVH

// data space byte addresses
`define MMS_DA_PORTA        8'h00
`define MMS_DA_PORTB        8'h01
`define MMS_DA_PORTC        8'h02
`define MMS_DA_DDRA         8'h04
`define MMS_DA_DDRB         8'h05
`define MMS_DA_DDRC         8'h06
`define MMS_DA_TSCR         8'h09
`define MMS_DA_ROM_LO       8'h20
`define MMS_DA_ROM_HI       8'h5F
`define MMS_DA_RAM_LO       8'h80
`define MMS_DA_RAM_HI       8'h9F
`define MMS_DA_PRESC        8'hFD
`define MMS_DA_COUNT        8'hFE
`define MMS_DA_ACC          8'hFF

// geometry
`define MMS_PROG_AW         12
`define MMS_DATA_AW         8
`define MMS_RAM_AW          5
`define MMS_RAM_DEPTH       32
`define MMS_DROM_DEPTH      64
`define MMS_STACK_DEPTH     4
`define MMS_NARROW_W        4
`define MMS_WIDE_W          8

// timer status/control fields
`define MMS_TSCR_TMZ        7
`define MMS_TSCR_DOUT       6
`define MMS_TSCR_TOUT       5
`define MMS_TSCR_RST        8'h00

// program space regions
`define MMS_PS_PROG_LO      12'h400
`define MMS_PS_PROG_HI      12'h7EF
`define MMS_PS_VEC_LO       12'h7F8
`define MMS_PS_VEC_HI       12'h7FF
`define MMS_PS_SELF_LO      12'hC00
`define MMS_PS_SELF_HI      12'hD2F

// restart addresses
`define MMS_VEC_USER        12'h400
`define MMS_VEC_SELF        12'hC00
`define MMS_VEC_ROMV        12'h000

// port-A bit positions of the two mode lines within the narrow port
`define MMS_MODE_LO_BIT     2
`define MMS_MODE_HI_BIT     3

`endif

/* mms_pkg.sv */
// mms_pkg: types shared by the mode/map block.
// assumes mms_consts.svh is on the include path.
`include "mms_consts.svh"

package mms_pkg;

  typedef enum logic [1:0] {
    MMS_MODE_SINGLE = 2'b00,
    MMS_MODE_SELF   = 2'b01,
    MMS_MODE_ROMV   = 2'b10
  } mms_mode_t;

  typedef enum logic [1:0] {
    MMS_REG_NONE = 2'b00,
    MMS_REG_PROG = 2'b01,
    MMS_REG_VEC  = 2'b10,
    MMS_REG_SELF = 2'b11
  } mms_region_t;

endpackage : mms_pkg

/* mms_mem_if.sv */
// mms_mem_if: port bundle between the map decoder and the data RAM.
// assumes one clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none

interface mms_mem_if #(
  parameter int AW = 5,
  parameter int DW = 8
);
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          we;
  logic [DW-1:0] rdata;

  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface : mms_mem_if

`default_nettype wire

/* mms_ram.sv */
// mms_ram: data space RAM, including the two pointer bytes at its bottom.
// assumes synchronous write, read data registered one cycle after the address.
`timescale 1ns/100ps
`default_nettype none

module mms_ram #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input  wire logic mclk_i,
  mms_mem_if.mem    bus
);
  logic [DW-1:0] mem_q [2**AW];

  // plain storage, no reset: contents are undefined until software writes them
  always_ff @(posedge mclk_i) begin
    if (bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
    end
  end

  // registered read keeps the timing independent of the decoder
  always_ff @(posedge mclk_i) begin
    bus.rdata <= mem_q[bus.addr];
  end
endmodule : mms_ram

`default_nettype wire

/* mms_top.sv */
// mms_top: reset-time mode select, restart vector, return stack, pin routing and
// data/program space decode of a small 8-bit single-chip controller.
// assumes the cpu core drives the data and program request ports synchronously to mclk_i.
`timescale 1ns/100ps
`default_nettype none
`include "mms_consts.svh"

module mms_top #(
  parameter logic [7:0]   MODE_TABLE = 8'h24,   // entry n at [2n+1:2n], n = {hi,lo}
  parameter logic [511:0] DROM_INIT  = 512'h0   // data ROM bytes indexed by address bits 5:0, so the low byte is read at 8'h40
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  mode_strap_pin_i,
  input  wire logic                  irq_n_i,
  output logic                       irq_o,
  input  wire logic                  timer_pin_i,
  output logic                       timer_pin_o,
  output logic                       timer_pin_oe_o,
  input  wire logic                  timer_timeout_i,
  input  wire logic                  int_sync_tick_i,
  output logic                       prescaler_clk_o,
  input  wire logic [3:0]            narrow_port_lines_i,
  output logic [3:0]                 narrow_port_lines_o,
  output logic [3:0]                 narrow_port_lines_oe_o,
  input  wire logic [7:0]            wide_port_lines_i,
  output logic [7:0]                 wide_port_lines_o,
  output logic [7:0]                 wide_port_lines_oe_o,
  input  wire logic [7:0]            d_addr_i,
  input  wire logic [7:0]            d_wdata_i,
  input  wire logic                  d_wr_i,
  input  wire logic                  d_rd_i,
  output logic [7:0]                 d_rdata_o,
  output logic                       d_rvalid_o,
  input  wire logic                  pc_inc_i,
  input  wire logic                  pc_load_i,
  input  wire logic                  call_i,
  input  wire logic                  ret_i,
  input  wire logic [11:0]           pc_target_i,
  output logic [11:0]                instruction_pointer_o,
  output mms_pkg::mms_region_t       prog_region_o,
  output mms_pkg::mms_mode_t         op_mode_o,
  output logic                       mode_valid_o,
  output logic [7:0]                 acc_o
);
  import mms_pkg::*;

  localparam int SD = `MMS_STACK_DEPTH;

  logic        booted_q;
  logic        irq_meta_q;
  logic [3:0]  pa_data_q;
  logic [7:0]  pb_data_q;
  logic [7:0]  pc_data_q;
  logic [3:0]  pa_dir_q;
  logic [7:0]  pb_dir_q;
  logic [7:0]  pc_dir_q;
  logic [7:0]  tscr_q;
  logic [7:0]  presc_q;
  logic [7:0]  count_q;
  logic [11:0] stack_q [SD];
  logic [7:0]  local_q;
  logic        ram_sel_q;
  logic        rd_q;
  logic [1:0]  mode_idx;
  logic        in_ram;
  logic        in_drom;
  logic        wr_ram;
  logic [7:0]  rd_mux;
  logic [11:0] boot_vec;

  mms_mem_if #(.AW(`MMS_RAM_AW), .DW(8)) ram_bus ();

  mms_ram #(
    .AW (`MMS_RAM_AW),
    .DW (8)
  ) u_ram (
    .mclk_i (mclk_i),
    .bus    (ram_bus.mem)
  );

  // data space decode; each space has its own address, never shared
  assign in_ram  = (d_addr_i >= `MMS_DA_RAM_LO) && (d_addr_i <= `MMS_DA_RAM_HI);
  assign in_drom = (d_addr_i >= `MMS_DA_ROM_LO) && (d_addr_i <= `MMS_DA_ROM_HI);
  assign wr_ram  = d_wr_i && in_ram;
  // pointer bytes are simply the first two RAM cells
  assign ram_bus.addr  = d_addr_i[`MMS_RAM_AW-1:0];
  assign ram_bus.wdata = d_wdata_i;
  assign ram_bus.we    = wr_ram;

  // mode decode: strap low forces single-chip, else the parameter table decides
  assign mode_idx = {narrow_port_lines_i[`MMS_MODE_HI_BIT], narrow_port_lines_i[`MMS_MODE_LO_BIT]};

  // release of reset is caught by the first clock edge after it, never in the reset branch
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      booted_q     <= 1'b0;
      mode_valid_o <= 1'b0;
      op_mode_o    <= MMS_MODE_SINGLE;
    end else if (!booted_q) begin
      booted_q     <= 1'b1;
      mode_valid_o <= 1'b1;
      if (!mode_strap_pin_i) begin
        op_mode_o <= MMS_MODE_SINGLE;
      end else begin
        op_mode_o <= mms_mode_t'(MODE_TABLE[{mode_idx, 1'b0} +: 2]);
      end
    end
    // once booted nothing touches the mode again
  end

  always_comb begin
    boot_vec = `MMS_VEC_USER;
    if (mode_strap_pin_i) begin
      unique case (mms_mode_t'(MODE_TABLE[{mode_idx, 1'b0} +: 2]))
        MMS_MODE_SINGLE: boot_vec = `MMS_VEC_USER;
        MMS_MODE_SELF:   boot_vec = `MMS_VEC_SELF;
        MMS_MODE_ROMV:   boot_vec = `MMS_VEC_ROMV;
        default:         boot_vec = `MMS_VEC_USER;  // unused table code falls back to user
      endcase
    end
  end

  // instruction pointer: reset abandons the program, boot loads the restart address
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      instruction_pointer_o <= 12'h000;
    end else if (!booted_q) begin
      instruction_pointer_o <= boot_vec;
    end else if (call_i || pc_load_i) begin
      instruction_pointer_o <= pc_target_i;
    end else if (ret_i) begin
      instruction_pointer_o <= stack_q[0];
    end else if (pc_inc_i) begin
      instruction_pointer_o <= instruction_pointer_o + 12'h001;         // wraps in 4096 bytes
    end
  end

  // return stack: push shifts down and drops the bottom, pull keeps the bottom level
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < SD; i++) begin
        stack_q[i] <= 12'h000;
      end
    end else if (booted_q && call_i) begin
      stack_q[0] <= instruction_pointer_o;
      for (int i = 1; i < SD; i++) begin
        stack_q[i] <= stack_q[i-1];
      end
    end else if (booted_q && ret_i) begin
      for (int i = 0; i < SD - 1; i++) begin
        stack_q[i] <= stack_q[i+1];
      end
    end
  end

  // program space region of the pointer, registered one cycle behind it, so the core need not know the layout
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_region_o <= MMS_REG_NONE;
    end else if ((instruction_pointer_o >= `MMS_PS_VEC_LO)
                 && (instruction_pointer_o <= `MMS_PS_VEC_HI)) begin
      prog_region_o <= MMS_REG_VEC;
    end else if ((instruction_pointer_o >= `MMS_PS_PROG_LO)
                 && (instruction_pointer_o <= `MMS_PS_PROG_HI)) begin
      prog_region_o <= MMS_REG_PROG;
    end else if ((instruction_pointer_o >= `MMS_PS_SELF_LO)
                 && (instruction_pointer_o <= `MMS_PS_SELF_HI)) begin
      prog_region_o <= MMS_REG_SELF;
    end else begin
      prog_region_o <= MMS_REG_NONE;
    end
  end

  // external interrupt: first flop feeds only the second
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_meta_q <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      irq_meta_q <= ~irq_n_i;
      irq_o      <= irq_meta_q;
    end
  end

  // port data and direction bytes, written by software
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pa_data_q <= 4'h0;
      pb_data_q <= 8'h00;
      pc_data_q <= 8'h00;
      pa_dir_q  <= 4'h0;  // all inputs after reset so the mode lines are not driven
      pb_dir_q  <= 8'h00;
      pc_dir_q  <= 8'h00;
    end else if (d_wr_i) begin
      unique case (d_addr_i)
        `MMS_DA_PORTA: pa_data_q <= d_wdata_i[7:4];
        `MMS_DA_PORTB: pb_data_q <= d_wdata_i;
        `MMS_DA_PORTC: pc_data_q <= d_wdata_i;
        `MMS_DA_DDRA:  pa_dir_q  <= d_wdata_i[7:4];
        `MMS_DA_DDRB:  pb_dir_q  <= d_wdata_i;
        `MMS_DA_DDRC:  pc_dir_q  <= d_wdata_i;
        default: ;
      endcase
    end
  end

  // pin drive registered so every line changes one cycle after the write
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      narrow_port_lines_o    <= 4'h0;
      narrow_port_lines_oe_o <= 4'h0;
      wide_port_lines_o      <= 8'h00;
      wide_port_lines_oe_o   <= 8'h00;
    end else begin
      narrow_port_lines_o    <= pa_data_q;
      narrow_port_lines_oe_o <= pa_dir_q;
      wide_port_lines_o      <= pb_data_q;
      wide_port_lines_oe_o   <= pb_dir_q;
    end
  end

  // timer status/control; a time-out in the same cycle as a clearing write still sets TMZ
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tscr_q <= `MMS_TSCR_RST;
    end else begin
      if (d_wr_i && (d_addr_i == `MMS_DA_TSCR)) begin
        tscr_q <= d_wdata_i;
      end
      if (timer_timeout_i || (d_wr_i && (d_addr_i == `MMS_DA_COUNT) && (d_wdata_i == 8'h00))) begin
        tscr_q[`MMS_TSCR_TMZ] <= 1'b1;
      end
    end
  end

  // prescaler, count and accumulator bytes; the counting itself lives in the timer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_q <= 8'h00;
      count_q <= 8'h00;
      acc_o   <= 8'h00;
    end else if (d_wr_i) begin
      unique case (d_addr_i)
        `MMS_DA_PRESC: presc_q <= d_wdata_i;
        `MMS_DA_COUNT: count_q <= d_wdata_i;
        `MMS_DA_ACC:   acc_o   <= d_wdata_i;
        default: ;
      endcase
    end
  end

  // timer pin: input mode clocks the prescaler, output mode shows DOUT at time-out
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescaler_clk_o <= 1'b0;
      timer_pin_o     <= 1'b0;
      timer_pin_oe_o  <= 1'b0;
    end else begin
      timer_pin_oe_o  <= tscr_q[`MMS_TSCR_TOUT];
      prescaler_clk_o <= tscr_q[`MMS_TSCR_TOUT] ? int_sync_tick_i : timer_pin_i;
      if (tscr_q[`MMS_TSCR_TOUT] && timer_timeout_i) begin
        timer_pin_o <= tscr_q[`MMS_TSCR_DOUT];
      end
    end
  end

  // local read mux; unmapped and expansion bytes read as zero
  always_comb begin
    rd_mux = 8'h00;
    if (in_drom) begin
      rd_mux = DROM_INIT[{d_addr_i[5:0], 3'b000} +: 8];
    end else begin
      unique case (d_addr_i)
        `MMS_DA_PORTA: rd_mux = {(pa_dir_q & pa_data_q) | (~pa_dir_q & narrow_port_lines_i), 4'h0};
        `MMS_DA_PORTB: rd_mux = (pb_dir_q & pb_data_q) | (~pb_dir_q & wide_port_lines_i);
        `MMS_DA_PORTC: rd_mux = pc_dir_q & pc_data_q;  // no pins behind it
        `MMS_DA_DDRA:  rd_mux = {pa_dir_q, 4'h0};
        `MMS_DA_DDRB:  rd_mux = pb_dir_q;
        `MMS_DA_DDRC:  rd_mux = pc_dir_q;
        `MMS_DA_TSCR:  rd_mux = tscr_q;
        `MMS_DA_PRESC: rd_mux = presc_q;
        `MMS_DA_COUNT: rd_mux = count_q;
        `MMS_DA_ACC:   rd_mux = acc_o;
        default:       rd_mux = 8'h00;
      endcase
    end
  end

  // two-stage read so the RAM and local bytes return with one latency
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      local_q    <= 8'h00;
      ram_sel_q  <= 1'b0;
      rd_q       <= 1'b0;
      d_rdata_o  <= 8'h00;
      d_rvalid_o <= 1'b0;
    end else begin
      local_q    <= rd_mux;
      ram_sel_q  <= in_ram;
      rd_q       <= d_rd_i;
      d_rvalid_o <= rd_q;
      d_rdata_o  <= ram_sel_q ? ram_bus.rdata : local_q;
    end
  end
endmodule : mms_top

`default_nettype wire

/* mms_top_props.sv */
// mms_top_props: concurrent checks on the ports of the mode/map block.
// assumes mms_pkg and mms_consts.svh are compiled first; attached by bind below.
`timescale 1ns/100ps
`default_nettype none
`include "mms_consts.svh"

module mms_top_props
  import mms_pkg::*;
#(
  parameter logic [7:0] MODE_TABLE = 8'h24
) (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        mode_strap_pin_i,
  input wire logic        irq_n_i,
  input wire logic        irq_o,
  input wire logic        timer_pin_i,
  input wire logic        timer_pin_o,
  input wire logic        timer_pin_oe_o,
  input wire logic        timer_timeout_i,
  input wire logic        prescaler_clk_o,
  input wire logic [3:0]  narrow_port_lines_i,
  input wire logic [7:0]  d_addr_i,
  input wire logic [7:0]  d_wdata_i,
  input wire logic        d_wr_i,
  input wire logic        d_rd_i,
  input wire logic        d_rvalid_o,
  input wire logic        call_i,
  input wire logic [11:0] pc_target_i,
  input wire logic [11:0] instruction_pointer_o,
  input wire mms_mode_t   op_mode_o,
  input wire logic        mode_valid_o,
  input wire logic [7:0]  acc_o
);
  logic [1:0] up_q;

  // edges since reset release; $past looks into reset before this saturates
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_irq_two_flops: assert property (up_q[1] |-> irq_o == !$past(irq_n_i, 2))
    else $error("interrupt not synchronised in two cycles");
  a_mode_held: assert property (up_q[1] |-> $stable(op_mode_o) && mode_valid_o)
    else $error("latched mode moved after boot");
  a_mode_decode: assert property ($rose(mode_valid_o) |-> op_mode_o ==
    ($past(mode_strap_pin_i) ? MODE_TABLE[{$past(narrow_port_lines_i[3:2]), 1'b0} +: 2]
                             : MMS_MODE_SINGLE))
    else $error("mode latched at boot is wrong");
  a_restart_vec: assert property ($rose(mode_valid_o) |-> instruction_pointer_o ==
    (op_mode_o == MMS_MODE_SELF ? `MMS_VEC_SELF :
     op_mode_o == MMS_MODE_ROMV ? `MMS_VEC_ROMV : `MMS_VEC_USER))
    else $error("restart pointer does not match mode");
  a_presc_route: assert property (up_q != 2'h0 && !timer_pin_oe_o |->
    prescaler_clk_o == $past(timer_pin_i))
    else $error("timer pin not routed to prescaler");
  a_pin_on_timeout: assert property (up_q[1] && $changed(timer_pin_o) |->
    $past(timer_timeout_i) || $past(timer_timeout_i, 2))
    else $error("timer pin moved without a timeout");
  a_acc_top: assert property (d_wr_i && d_addr_i == `MMS_DA_ACC |=>
    acc_o == $past(d_wdata_i))
    else $error("top data byte is not the accumulator");
  a_read_answer: assert property (d_rd_i |-> ##2 d_rvalid_o)
    else $error("read not answered in two cycles");
  a_no_stray_valid: assert property (up_q[1] && d_rvalid_o |-> $past(d_rd_i, 2))
    else $error("read valid without a read");
  a_call_target: assert property (up_q != 2'h0 && call_i |=>
    instruction_pointer_o == $past(pc_target_i))
    else $error("call did not load its target");
endmodule : mms_top_props

bind mms_top mms_top_props #(.MODE_TABLE(MODE_TABLE)) chk_u (
  .mclk_i, .rst_n_i, .mode_strap_pin_i, .irq_n_i, .irq_o, .timer_pin_i, .timer_pin_o,
  .timer_pin_oe_o, .timer_timeout_i, .prescaler_clk_o, .narrow_port_lines_i, .d_addr_i,
  .d_wdata_i, .d_wr_i, .d_rd_i, .d_rvalid_o, .call_i, .pc_target_i,
  .instruction_pointer_o, .op_mode_o, .mode_valid_o, .acc_o
);

`default_nettype wire

/* mms_board.sv */
// mms_board: board reset and mode strap wiring for the mode/map block.
// assumes boot_i is a one-cycle request from the bench on the same clock.
`timescale 1ns/100ps
`default_nettype none

module mms_board #(
  parameter int RST_CYC = 20
) (
  input  wire logic       mclk_i,
  input  wire logic       boot_i,
  input  wire logic       strap_cfg_i,
  input  wire logic [1:0] lines_cfg_i,
  output logic            rst_n_o,
  output logic            strap_o,
  output logic [1:0]      lines_o
);
  logic [5:0] cnt_q;
  logic       hold;

  // cycles since the boot request, saturating
  always_ff @(posedge mclk_i) begin
    if (boot_i) cnt_q <= 6'h00;
    else if (cnt_q != 6'h3F) cnt_q <= cnt_q + 6'h01;
  end

  // reset pulse, then straps held two edges past release
  assign rst_n_o = !(boot_i || cnt_q < 6'(RST_CYC));
  assign hold    = boot_i || cnt_q <= 6'(RST_CYC + 1);
  // once the hold ends the straps flip, so a late sample would be caught
  assign strap_o = hold ? strap_cfg_i : !strap_cfg_i;
  assign lines_o = hold ? lines_cfg_i : ~lines_cfg_i;
endmodule : mms_board

`default_nettype wire

/* mms_top_bench.sv */
// mms_top_bench: self-checking bench for the mode/map block.
// assumes mms_pkg, mms_top, mms_board and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

module mms_top_bench;
  import mms_pkg::*;
  logic        mclk_i, boot, strap_cfg, irq_n_i, timer_pin_i, timer_timeout_i;
  logic        int_sync_tick_i, d_wr_i, d_rd_i, pc_inc_i, pc_load_i, call_i, ret_i;
  logic [1:0]  lines_cfg, nlow;
  logic [7:0]  wide_port_lines_i, d_addr_i, d_wdata_i, dv, ev;
  logic [11:0] pc_target_i, p0;
  logic        rst_n_i, mode_strap_pin_i, irq_o, timer_pin_o, timer_pin_oe_o;
  logic        prescaler_clk_o, d_rvalid_o, mode_valid_o;
  logic [1:0]  mlines;
  logic [3:0]  narrow_port_lines_i, narrow_port_lines_o, narrow_port_lines_oe_o;
  logic [7:0]  wide_port_lines_o, wide_port_lines_oe_o, d_rdata_o, acc_o;
  logic [11:0] instruction_pointer_o;
  mms_region_t prog_region_o;
  mms_mode_t   op_mode_o;
  int          mismatches, num_checks;

  assign narrow_port_lines_i = {mlines, nlow};

  mms_top dut_u (.mclk_i, .rst_n_i, .mode_strap_pin_i, .irq_n_i, .irq_o, .timer_pin_i,
    .timer_pin_o, .timer_pin_oe_o, .timer_timeout_i, .int_sync_tick_i, .prescaler_clk_o,
    .narrow_port_lines_i, .narrow_port_lines_o, .narrow_port_lines_oe_o,
    .wide_port_lines_i, .wide_port_lines_o, .wide_port_lines_oe_o, .d_addr_i, .d_wdata_i,
    .d_wr_i, .d_rd_i, .d_rdata_o, .d_rvalid_o, .pc_inc_i, .pc_load_i, .call_i, .ret_i,
    .pc_target_i, .instruction_pointer_o, .prog_region_o, .op_mode_o, .mode_valid_o, .acc_o);

  mms_board #(.RST_CYC(20)) board_u (.mclk_i, .boot_i(boot), .strap_cfg_i(strap_cfg),
    .lines_cfg_i(lines_cfg), .rst_n_o(rst_n_i), .strap_o(mode_strap_pin_i), .lines_o(mlines));

  // 125 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // idle inputs wander so the routing checks see real traffic
  always @(posedge mclk_i) begin
    timer_pin_i       <= 1'($urandom);
    int_sync_tick_i   <= 1'($urandom);
    wide_port_lines_i <= 8'($urandom);
    nlow              <= 2'($urandom);
  end

  // mode chosen by strap and {hi,lo} under the default table
  function automatic logic [1:0] exp_mode(input logic s, input logic [1:0] l);
    if (!s || l == 2'h3) return 2'h0;
    return l;
  endfunction : exp_mode

  function automatic logic [11:0] exp_vec(input logic [1:0] m);
    return (m == 2'h1) ? 12'hC00 : (m == 2'h2) ? 12'h000 : 12'h400;
  endfunction : exp_vec

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    d_addr_i  <= a;
    d_wdata_i <= d;
    d_wr_i    <= 1'b1;
    @(posedge mclk_i);
    d_wr_i <= 1'b0;
  endtask : wr

  // answer is launched one edge after the taking edge and stands for one cycle only,
  // so it is looked at just after that launch, before the next edge clears valid
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    d_addr_i <= a;
    d_rd_i   <= 1'b1;
    @(posedge mclk_i);
    d_rd_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk(12'(d_rvalid_o), 12'h1, "read valid missing");
    chk(12'(d_rdata_o), 12'(exp), "read data");
  endtask : rd

  // op is {inc, load, call, ret}
  task automatic pcop(input logic [3:0] op, input logic [11:0] t);
    @(posedge mclk_i);
    {pc_inc_i, pc_load_i, call_i, ret_i} <= op;
    pc_target_i <= t;
    @(posedge mclk_i);
    {pc_inc_i, pc_load_i, call_i, ret_i} <= 4'h0;
    #1;
  endtask : pcop

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  initial begin
    repeat (6000) @(posedge mclk_i);
    mismatches++;
    end_sim();
  end

  initial begin
    logic [1:0] m;
    logic [11:0] rg [4];
    // boot held high keeps the board in reset; interrupt idle high, no time-out
    {boot, strap_cfg, lines_cfg, irq_n_i, timer_timeout_i} = 6'h22;
    {d_wr_i, d_rd_i, pc_inc_i, pc_load_i, call_i, ret_i} = 6'h00;
    {d_addr_i, d_wdata_i, pc_target_i} = 28'h0;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(32'hD04CB1F8));
    rg = '{12'h400, 12'h7FF, 12'hD2F, 12'hD30};
    // boot with strap low, then strap high in every line setting; pointer moved away first, except before the first boot while reset still holds
    for (int i = 0; i < 5; i++) begin
      pcop(4'h4, 12'($urandom));
      @(posedge mclk_i);
      strap_cfg <= (i > 0);
      lines_cfg <= (i > 0) ? 2'(i - 1) : 2'($urandom);
      boot      <= 1'b1;
      @(posedge mclk_i);
      boot <= 1'b0;
      m = exp_mode(strap_cfg, lines_cfg);
      repeat (21) @(posedge mclk_i);
      #1;
      chk(12'(mode_valid_o), 12'h1, "mode not valid");
      chk(12'(op_mode_o), 12'(m), "boot mode");
      chk(instruction_pointer_o, exp_vec(m), "restart pointer");
      repeat (4) @(posedge mclk_i);
      #1;
      chk(12'(op_mode_o), 12'(m), "mode moved with straps");
    end
    $display("test boot done");
    // data space: ram, pointers, accumulator, rom, unused holes
    foreach (rg[k]) begin
      dv = 8'($urandom);
      wr(8'h80 + 8'(k) + ((k == 3) ? 8'h1C : 8'h0), dv);
      rd(8'h80 + 8'(k) + ((k == 3) ? 8'h1C : 8'h0), dv);
    end
    dv = 8'($urandom);
    wr(8'hFF, dv);
    #1;
    chk(12'(acc_o), 12'(dv), "accumulator");
    rd(8'hFF, dv);
    wr(8'h20, 8'hAA);
    rd(8'h20, 8'h00);
    wr(8'h60, 8'h55);
    rd(8'h60, 8'h00);
    rd(8'hA0, 8'h00);
    // port directions and data
    dv = 8'($urandom);
    ev = 8'($urandom);
    wr(8'h05, dv);
    wr(8'h01, ev);
    wr(8'h04, ev);
    wr(8'h00, dv);
    repeat (2) @(posedge mclk_i);
    #1;
    chk(12'(wide_port_lines_oe_o), 12'(dv), "wide direction");
    chk(12'(wide_port_lines_o), 12'(ev), "wide data");
    chk(12'(narrow_port_lines_oe_o), 12'(ev[7:4]), "narrow direction");
    chk(12'(narrow_port_lines_o), 12'(dv[7:4]), "narrow data");
    $display("test data done");
    // program space: wrap, regions, stack
    pcop(4'h4, 12'hFFF);
    pcop(4'h8, 12'h000);
    chk(instruction_pointer_o, 12'h000, "pointer wrap");
    foreach (rg[k]) begin
      pcop(4'h4, rg[k]);
      @(posedge mclk_i);
      #1;
      chk(12'(prog_region_o), (k == 3) ? 12'h0 : 12'(k + 1), "region");
    end
    p0 = 12'($urandom);
    pcop(4'h4, p0);
    pcop(4'h2, 12'h123);
    pcop(4'h2, 12'hABC);
    pcop(4'h1, 12'h000);
    chk(instruction_pointer_o, 12'h123, "first return");
    pcop(4'h1, 12'h000);
    chk(instruction_pointer_o, p0, "second return");
    $display("test program done");
    // interrupt and timer pin
    @(posedge mclk_i);
    irq_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(12'(irq_o), 12'h1, "interrupt");
    irq_n_i <= 1'b1;
    wr(8'h09, 8'h00);
    repeat (8) @(posedge mclk_i);
    #1;
    chk(12'(timer_pin_oe_o), 12'h0, "timer pin input");
    for (int d = 1; d >= 0; d--) begin
      wr(8'h09, d[0] ? 8'h60 : 8'h20);
      @(posedge mclk_i);
      timer_timeout_i <= 1'b1;
      @(posedge mclk_i);
      timer_timeout_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      chk(12'(timer_pin_oe_o), 12'h1, "timer pin output");
      chk(12'(timer_pin_o), 12'(d[0]), "timeout level");
    end
    $display("test timer done");
    end_sim();
  end
endmodule : mms_top_bench

`default_nettype wire
